// file: rtl/memory_type_range_lookup.v
// Purpose: range-based memory-type registers and lookup for one core
// Assumes: register and query strobes come from logic on sys_clk
// Notes: answers arrive one cycle after the strobe, from flip-flops
`timescale 1ns/1ns
`include "range_lookup_defs.vh"

module memory_type_range_lookup (
    input wire sys_clk,
    input wire rst,
    input wire reg_rd,
    input wire reg_wr,
    input wire [11:0] reg_idx,
    input wire [63:0] reg_wdata,
    output reg [63:0] reg_rdata_ff,
    output reg reg_done_ff,
    output reg general_protection_fault_ff,
    input wire id_query,
    output reg [31:0] feature_result_register_ff,
    output reg id_done_ff,
    input wire lookup_req,
    input wire [51:0] lookup_addr,
    output reg [7:0] lookup_type_ff,
    output reg lookup_done_ff
);

    reg [63:0] fixed_ff [0:`FIXED_REG_NUM-1];
    reg [7:0] base_type_ff [0:`PAIR_NUM-1];
    reg [39:0] base_addr_ff [0:`PAIR_NUM-1];
    reg [39:0] mask_addr_ff [0:`PAIR_NUM-1];
    reg [`PAIR_NUM-1:0] pair_valid_ff;
    reg [7:0] default_type_ff;
    reg fixed_on_ff;
    reg typing_on_ff;

    reg [63:0] rd_word;
    reg idx_known;
    reg wr_legal;
    reg [7:0] var_present;
    reg [7:0] var_type;
    reg [7:0] fixed_type;
    reg [7:0] nxt_lookup_type;
    reg [4:0] fixed_slot;
    reg [7:0] seg;
    reg fixed_hit;
    reg [7:0] seg_off;
    wire [39:0] target_page;
    wire [`PAIR_NUM-1:0] pair_hit;
    wire [7:0] fixed_byte [0:`FIXED_REG_NUM*8-1];
    wire refused;
    genvar g;
    wire [2:0] pair_sel;
    wire is_var;
    wire is_mask;
    integer i;
    integer k;

    assign is_var = (reg_idx >= `IDX_VAR_FIRST) && (reg_idx <= `IDX_VAR_LAST);
    assign pair_sel = reg_idx[3:1];
    assign is_mask = reg_idx[0];
    // full 52-bit target, fields cut at bits 51:12
    assign target_page = lookup_addr[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
    // refused accesses fault and store nothing
    assign refused = (reg_rd && !idx_known) || (reg_wr && !wr_legal);

    // one comparator per pair, no priority among them
    generate
        for (g = 0; g < `PAIR_NUM; g = g + 1) begin : pair_cmp
            wire [39:0] masked_base;
            wire [39:0] masked_target;
            assign masked_base = mask_addr_ff[g] & base_addr_ff[g];
            assign masked_target = mask_addr_ff[g] & target_page;
            // a cleared valid flag keeps the pair out
            assign pair_hit[g] = pair_valid_ff[g] && (masked_base == masked_target);
        end
    endgenerate

    // one byte per 4K segment, segment e8 first
    generate
        for (g = 0; g < `FIXED_REG_NUM * 8; g = g + 1) begin : fixed_seg
            // lowest segment in bits 7:0, upward by byte
            assign fixed_byte[g] = fixed_ff[g / 8][(g % 8) * 8 +: 8];
        end
    endgenerate

    // only standard encodings count as legal
    // reserved type bits 7:3 must be zero, which the compare covers
    function std_type;
        input [7:0] t;
        begin
            std_type = (t == `TYPE_UNCACHED) || (t == `TYPE_COMBINING) ||
                (t == `TYPE_WRITE_THROUGH) || (t == `TYPE_WRITE_PROTECT) ||
                (t == `TYPE_WRITE_BACK);
        end
    endfunction

    function all_std;
        input [63:0] w;
        integer j;
        begin
            all_std = 1'b1;
            for (j = 0; j < 8; j = j + 1) begin
                if (!std_type(w[j*8 +: 8])) begin
                    all_std = 1'b0;
                end
            end
        end
    endfunction

    // register read mux and write legality
    always @* begin
        rd_word = 64'h0000000000000000;
        idx_known = 1'b1;
        wr_legal = 1'b1;
        if (is_var) begin
            // pair fields read back as written
            if (is_mask) begin
                rd_word[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB] = mask_addr_ff[pair_sel];
                rd_word[`PAIR_VALID_BIT] = pair_valid_ff[pair_sel];
            end else begin
                rd_word[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB] = base_addr_ff[pair_sel];
                rd_word[`TYPE_MSB:0] = base_type_ff[pair_sel];
                // extended encodings refused in the base type
                wr_legal = std_type(reg_wdata[`TYPE_MSB:0]);
            end
        end else begin
            case (reg_idx)
                `IDX_FIXED_E8000: begin
                    rd_word = fixed_ff[0];
                    wr_legal = all_std(reg_wdata);
                end
                `IDX_FIXED_F0000: begin
                    rd_word = fixed_ff[1];
                    wr_legal = all_std(reg_wdata);
                end
                `IDX_FIXED_F8000: begin
                    rd_word = fixed_ff[2];
                    wr_legal = all_std(reg_wdata);
                end
                `IDX_DEFAULT_TYPE: begin
                    rd_word[`TYPE_MSB:0] = default_type_ff;
                    rd_word[`FIXED_ON_BIT] = fixed_on_ff;
                    rd_word[`TYPING_ON_BIT] = typing_on_ff;
                    // default field takes standard encodings only
                    wr_legal = std_type(reg_wdata[`TYPE_MSB:0]);
                end
                `IDX_CAPABILITY: begin
                    // pair count in the low byte
                    rd_word[7:0] = `PAIR_COUNT;
                    rd_word[`CAP_FIXED_BIT] = `FIXED_SUPPORTED;
                    rd_word[`CAP_COMBINING_BIT] = `COMBINING_SUPPORTED;
                    wr_legal = 1'b0;
                end
                default: begin
                    idx_known = 1'b0;
                    wr_legal = 1'b0;
                end
            endcase
        end
    end

    // register file
    always @(posedge sys_clk) begin
        if (rst) begin
            for (i = 0; i < `FIXED_REG_NUM; i = i + 1) begin
                fixed_ff[i] <= `RESET_WORD;
            end
            for (i = 0; i < `PAIR_NUM; i = i + 1) begin
                base_type_ff[i] <= 8'h00;
                base_addr_ff[i] <= 40'h0000000000;
                mask_addr_ff[i] <= 40'h0000000000;
            end
            pair_valid_ff <= 8'h00;
            default_type_ff <= `RESET_DEFAULT_TYPE;
            fixed_on_ff <= 1'b0;
            typing_on_ff <= 1'b0;
        // a write lands on this edge, so a lookup in the next cycle sees it
        end else if (reg_wr && wr_legal) begin
            if (is_var) begin
                if (is_mask) begin
                    // mask field, low twelve bits implied zero
                    mask_addr_ff[pair_sel] <= reg_wdata[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
                    pair_valid_ff[pair_sel] <= reg_wdata[`PAIR_VALID_BIT];
                end else begin
                    // base field, low twelve bits implied zero
                    base_addr_ff[pair_sel] <= reg_wdata[`ADDR_FIELD_MSB:`ADDR_FIELD_LSB];
                    base_type_ff[pair_sel] <= reg_wdata[`TYPE_MSB:0];
                end
            end else begin
                case (reg_idx)
                    `IDX_FIXED_E8000: begin
                        fixed_ff[0] <= reg_wdata;
                    end
                    `IDX_FIXED_F0000: begin
                        fixed_ff[1] <= reg_wdata;
                    end
                    `IDX_FIXED_F8000: begin
                        fixed_ff[2] <= reg_wdata;
                    end
                    `IDX_DEFAULT_TYPE: begin
                        default_type_ff <= reg_wdata[`TYPE_MSB:0];
                        fixed_on_ff <= reg_wdata[`FIXED_ON_BIT];
                        typing_on_ff <= reg_wdata[`TYPING_ON_BIT];
                    end
                    default: begin
                        fixed_on_ff <= fixed_on_ff;
                    end
                endcase
            end
        end
    end

    // register answer; a faulting write changes nothing
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata_ff <= 64'h0000000000000000;
            reg_done_ff <= 1'b0;
            general_protection_fault_ff <= 1'b0;
        end else begin
            reg_done_ff <= reg_rd || reg_wr;
            general_protection_fault_ff <= refused;
            // zero outside good reads, so no stale word shows with a later answer
            if (reg_rd && idx_known) begin
                reg_rdata_ff <= rd_word;
            end else begin
                reg_rdata_ff <= 64'h0000000000000000;
            end
        end
    end

    // identification query answer
    always @(posedge sys_clk) begin
        if (rst) begin
            feature_result_register_ff <= 32'h00000000;
            id_done_ff <= 1'b0;
        end else begin
            // result holds after the pulse, so a late reader still sees it
            id_done_ff <= id_query;
            if (id_query) begin
                feature_result_register_ff <= 32'h00000001 << `FEATURE_TYPING_BIT;
            end
        end
    end

    // lookup datapath
    always @* begin
        var_present = 8'h00;
        // identical types set the same bit, so one bit set means one type
        for (k = 0; k < `PAIR_NUM; k = k + 1) begin
            if (pair_hit[k]) begin
                var_present[base_type_ff[k][2:0]] = 1'b1;
            end
        end
        if (var_present[0]) begin
            var_type = `TYPE_UNCACHED;
        end else if (var_present == 8'h02) begin
            var_type = `TYPE_COMBINING;
        end else if (var_present == 8'h10) begin
            var_type = `TYPE_WRITE_THROUGH;
        end else if (var_present == 8'h20) begin
            var_type = `TYPE_WRITE_PROTECT;
        end else if (var_present == 8'h40) begin
            var_type = `TYPE_WRITE_BACK;
        end else if (var_present == 8'h50) begin
            var_type = `TYPE_WRITE_THROUGH;
        end else begin
            // undefined mixes resolve to the safest type
            var_type = `TYPE_UNCACHED;
        end
        seg = lookup_addr[19:12];
        fixed_hit = (lookup_addr[51:20] == 32'h00000000) && (seg >= `FIXED_FIRST_SEG);
        seg_off = seg - `FIXED_FIRST_SEG;
        fixed_slot = seg_off[4:0];
        if (fixed_slot < 5'd24) begin
            fixed_type = fixed_byte[fixed_slot];
        end else begin
            fixed_type = `TYPE_UNCACHED;
        end
        if (!typing_on_ff) begin
            nxt_lookup_type = `TYPE_UNCACHED;
        // fixed enable gates fixed ranges only
        // checked only under the global enable
        // fixed hit wins over variable hits
        end else if (fixed_on_ff && fixed_hit) begin
            nxt_lookup_type = fixed_type;
        end else if (var_present != 8'h00) begin
            nxt_lookup_type = var_type;
        end else begin
            // no hit takes the default type
            nxt_lookup_type = default_type_ff;
        end
    end

    // lookup answer one cycle after the request
    always @(posedge sys_clk) begin
        if (rst) begin
            lookup_type_ff <= `TYPE_UNCACHED;
            lookup_done_ff <= 1'b0;
        end else begin
            // type holds between requests, so a slow consumer may read it late
            lookup_done_ff <= lookup_req;
            if (lookup_req) begin
                lookup_type_ff <= nxt_lookup_type;
            end
        end
    end

endmodule // memory_type_range_lookup

// file: rtl/range_lookup_defs.vh
// Purpose: constants for the memory-type range lookup block
// Assumes: register indices are local model-register numbers
// Notes: register indices are arbitrary local choices
`ifndef RANGE_LOOKUP_DEFS_VH
`define RANGE_LOOKUP_DEFS_VH

// register indices
`define IDX_FIXED_E8000 12'h010
`define IDX_FIXED_F0000 12'h011
`define IDX_FIXED_F8000 12'h012
`define IDX_VAR_FIRST 12'h020
`define IDX_VAR_LAST 12'h02f
`define IDX_DEFAULT_TYPE 12'h030
`define IDX_CAPABILITY 12'h031

// type encodings
`define TYPE_UNCACHED 8'h00
`define TYPE_COMBINING 8'h01
`define TYPE_WRITE_THROUGH 8'h04
`define TYPE_WRITE_PROTECT 8'h05
`define TYPE_WRITE_BACK 8'h06

// field positions
`define TYPE_MSB 7
`define ADDR_FIELD_MSB 51
`define ADDR_FIELD_LSB 12
`define PAIR_VALID_BIT 11
`define FIXED_ON_BIT 10
`define TYPING_ON_BIT 11
`define CAP_FIXED_BIT 8
`define CAP_COMBINING_BIT 10
`define FEATURE_TYPING_BIT 12

// capability contents
`define PAIR_COUNT 8'h08
`define PAIR_NUM 8
`define FIXED_SUPPORTED 1'b1
`define COMBINING_SUPPORTED 1'b1

// fixed window of 4-Kbyte segments: segment numbers e8..ff
`define FIXED_FIRST_SEG 8'he8
`define FIXED_REG_NUM 3

// reset values
`define RESET_DEFAULT_CTRL 64'h0000000000000000
`define RESET_DEFAULT_TYPE 8'h00
`define RESET_WORD 64'h0000000000000000

`endif

// file: testbench/memory_type_range_lookup_chk.sv
// Purpose: port checks for the range lookup block
// Assumes: one clock, synchronous reset
// Notes: table contents are judged by the bench
`timescale 1ns/1ns
`include "range_lookup_defs.vh"
module memory_type_range_lookup_chk (
    input wire sys_clk,
    input wire rst,
    input wire reg_rd,
    input wire reg_wr,
    input wire [11:0] reg_idx,
    input wire [63:0] reg_wdata,
    input wire [63:0] reg_rdata_ff,
    input wire reg_done_ff,
    input wire general_protection_fault_ff,
    input wire id_query,
    input wire [31:0] feature_result_register_ff,
    input wire id_done_ff,
    input wire lookup_req,
    input wire [51:0] lookup_addr,
    input wire [7:0] lookup_type_ff,
    input wire lookup_done_ff
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    chk_reg_answer: assert property ((reg_rd || reg_wr) |=> reg_done_ff)
        else $error("access not answered");
    chk_reg_quiet: assert property (!(reg_rd || reg_wr) |=> !reg_done_ff && !general_protection_fault_ff)
        else $error("answer without access");
    chk_cap_refused: assert property (reg_wr && reg_idx == `IDX_CAPABILITY |=> general_protection_fault_ff)
        else $error("capability write accepted");
    chk_cap_count: assert property (reg_rd && reg_idx == `IDX_CAPABILITY |=> reg_rdata_ff[7:0] == 8'h08)
        else $error("pair count wrong");
    chk_cap_flags: assert property (reg_rd && reg_idx == `IDX_CAPABILITY |=> reg_rdata_ff[8] && reg_rdata_ff[10])
        else $error("capability flags wrong");
    chk_default_std: assert property (reg_wr && reg_idx == `IDX_DEFAULT_TYPE && !(reg_wdata[7:0] inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06}) |=> general_protection_fault_ff)
        else $error("odd default type accepted");
    chk_base_std: assert property (reg_wr && reg_idx >= `IDX_VAR_FIRST && reg_idx <= `IDX_VAR_LAST && !reg_idx[0] && !(reg_wdata[7:0] inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06}) |=> general_protection_fault_ff)
        else $error("odd base type accepted");
    chk_id_answer: assert property (id_query |=> id_done_ff && feature_result_register_ff == 32'h0000_1000)
        else $error("identification answer wrong");
    chk_lookup_answer: assert property (lookup_req |=> lookup_done_ff)
        else $error("lookup not answered");
    chk_type_hold: assert property (!lookup_req |=> $stable(lookup_type_ff) && !lookup_done_ff)
        else $error("type moved without lookup");
endmodule // memory_type_range_lookup_chk

bind memory_type_range_lookup memory_type_range_lookup_chk i_memory_type_range_lookup_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_idx(reg_idx),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_done_ff(reg_done_ff),
    .general_protection_fault_ff(general_protection_fault_ff), .id_query(id_query),
    .feature_result_register_ff(feature_result_register_ff), .id_done_ff(id_done_ff),
    .lookup_req(lookup_req), .lookup_addr(lookup_addr), .lookup_type_ff(lookup_type_ff),
    .lookup_done_ff(lookup_done_ff));

// file: testbench/memory_type_range_lookup_test.sv
// Purpose: random and corner tests of the range lookup block
// Assumes: shadow copies of the registers predict each answer
// Notes: random addresses stay in a 4 MB pool so ranges overlap often
`timescale 1ns/1ns
`include "range_lookup_defs.vh"
`define CHECK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module memory_type_range_lookup_test;
    reg sys_clk = 1'b0, rst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, id_query = 1'b0;
    reg lookup_req = 1'b0;
    reg [11:0] reg_idx = 12'h000;
    reg [63:0] reg_wdata = 64'h0, dflt = 64'h0, rs = 64'h50, r;
    reg [51:0] lookup_addr = 52'h0;
    reg [63:0] fx [0:2] = '{default: 64'h0};
    reg [63:0] vb [0:7] = '{default: 64'h0};
    reg [63:0] vm [0:7] = '{default: 64'h0};
    wire [63:0] reg_rdata_ff;
    wire [31:0] feature_result_register_ff;
    wire [7:0] lookup_type_ff;
    wire reg_done_ff, general_protection_fault_ff, id_done_ff, lookup_done_ff;
    int n_mismatch = 0, n_compared = 0, i;

    memory_type_range_lookup i_memory_type_range_lookup (
        .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_idx(reg_idx),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_done_ff(reg_done_ff),
        .general_protection_fault_ff(general_protection_fault_ff), .id_query(id_query),
        .feature_result_register_ff(feature_result_register_ff), .id_done_ff(id_done_ff),
        .lookup_req(lookup_req), .lookup_addr(lookup_addr), .lookup_type_ff(lookup_type_ff),
        .lookup_done_ff(lookup_done_ff));

    always #5 sys_clk = ~sys_clk;

    function automatic [63:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 7);
        rs = rs ^ (rs << 17);
        return rs;
    endfunction

    function automatic bit std(input [7:0] t);
        return t inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
    endfunction

    function automatic [7:0] exp_type(input [51:0] a);
        reg [7:0] seen, s;
        seen = 8'h00;
        s = a[19:12] - 8'he8;
        if (!dflt[11])
            return 8'h00;
        if (dflt[10] && a[51:20] == 32'h0 && a[19:12] >= 8'he8)
            return fx[s[4:3]][s[2:0] * 8 +: 8];
        for (int k = 0; k < 8; k++)
            if (vm[k][11] && (vm[k][51:12] & vb[k][51:12]) == (vm[k][51:12] & a[51:12]))
                seen[vb[k][2:0]] = 1'b1;
        // undefined mixes are taken as uncached
        case (seen)
            8'h00: return dflt[7:0];
            8'h02: return 8'h01;
            8'h10, 8'h50: return 8'h04;
            8'h20: return 8'h05;
            8'h40: return 8'h06;
            default: return 8'h00;
        endcase
    endfunction

    task automatic acc(input w, input [11:0] idx, input [63:0] d, e, input flt);
        @(posedge sys_clk);
        #1;
        {reg_wr, reg_rd, reg_idx, reg_wdata} = {w, !w, idx, d};
        @(posedge sys_clk);
        #1;
        {reg_wr, reg_rd} = 2'b00;
        `CHECK("reg_done", 1'b1, reg_done_ff)
        `CHECK("fault", flt, general_protection_fault_ff)
        if (!w) `CHECK("rdata", e, reg_rdata_ff)
    endtask

    task automatic wr(input [11:0] idx, input [63:0] d);
        bit flt;
        flt = 1'b0;
        if (idx >= `IDX_FIXED_E8000 && idx <= `IDX_FIXED_F8000) begin
            for (int k = 0; k < 8; k++)
                if (!std(d[8 * k +: 8])) flt = 1'b1;
            if (!flt) fx[idx[1:0]] = d;
        end else if (idx >= `IDX_VAR_FIRST && idx <= `IDX_VAR_LAST) begin
            if (idx[0]) vm[idx[3:1]] = d & 64'h000f_ffff_ffff_f800;
            else if (std(d[7:0])) vb[idx[3:1]] = d & 64'h000f_ffff_ffff_f0ff;
            else flt = 1'b1;
        end else if (idx == `IDX_DEFAULT_TYPE && std(d[7:0])) dflt = d & 64'h0000_0000_0000_0cff;
        else flt = 1'b1;
        acc(1'b1, idx, d, 64'h0, flt);
    endtask

    task automatic rd(input [11:0] idx);
        reg [63:0] e;
        e = 64'h0;
        if (idx >= `IDX_FIXED_E8000 && idx <= `IDX_FIXED_F8000) e = fx[idx[1:0]];
        else if (idx >= `IDX_VAR_FIRST && idx <= `IDX_VAR_LAST) e = idx[0] ? vm[idx[3:1]] : vb[idx[3:1]];
        else if (idx == `IDX_DEFAULT_TYPE) e = dflt;
        else if (idx == `IDX_CAPABILITY) e = 64'h0000_0000_0000_0508;
        acc(1'b0, idx, 64'h0, e, !((idx >= 12'h010 && idx <= 12'h012) || (idx >= 12'h020 && idx <= 12'h031)));
    endtask

    task automatic look(input [51:0] a);
        reg [7:0] e;
        e = exp_type(a);
        @(posedge sys_clk);
        #1;
        {lookup_req, lookup_addr} = {1'b1, a};
        @(posedge sys_clk);
        #1;
        {lookup_req, lookup_addr} = {1'b0, ~a};
        `CHECK("lookup_done", 1'b1, lookup_done_ff)
        `CHECK("lookup_type", e, lookup_type_ff)
    endtask

    task tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #200_000;
        n_mismatch++;
        tally_and_finish;
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        for (i = 16; i < 64; i++) rd(i[11:0]);
        wr(`IDX_CAPABILITY, 64'h0);
        @(posedge sys_clk);
        #1;
        id_query = 1'b1;
        @(posedge sys_clk);
        #1;
        id_query = 1'b0;
        `CHECK("id_done", 1'b1, id_done_ff)
        `CHECK("feature", 32'h0000_1000, feature_result_register_ff)
        wr(`IDX_FIXED_E8000, 64'h0605_0401_0006_0504);
        wr(`IDX_FIXED_F0000, 64'h0406_0500_0104_0605);
        wr(`IDX_FIXED_F8000, 64'h0104_0605_0400_0106);
        wr(`IDX_FIXED_F0000, 64'h0702_0000_0000_0000);
        wr(12'h020, 64'h0000_0000_0000_0006);
        wr(12'h021, 64'h000f_ffff_fff0_0800);
        wr(`IDX_DEFAULT_TYPE, 64'h0000_0000_0000_0406);
        look(52'h0_0000_000e_8000);
        wr(`IDX_DEFAULT_TYPE, 64'h0000_0000_0000_0c05);
        // segment e7 falls to the pair, e8..ff to the fixed bytes
        for (i = 0; i <= 24; i++) look({32'h0, 8'he7 + i[7:0], 12'hfff});
        wr(`IDX_DEFAULT_TYPE, 64'h0000_0000_0000_0805);
        look(52'h0_0000_000f_f000);
        look(52'h0_0000_0010_0000);
        wr(12'h022, 64'h0000_0000_0040_0004);
        wr(12'h023, 64'h000f_ffff_ffc0_0800);
        wr(12'h024, 64'h0000_0000_0040_0006);
        // write-through over write-back gives write-through
        wr(12'h025, 64'h000f_ffff_ffc0_0800);
        look(52'h0_0000_0040_1000);
        for (i = 0; i < 300; i++) begin
            r = rnd();
            case (r[1:0])
                2'd0: begin
                    // size set by pair number, base aligned to it
                    // mask is all ones above the size
                    // base bits 11:3 left zero, type in bits 2:0
                    wr(`IDX_VAR_FIRST + {8'h0, r[63:60]}, r[60] ?
                        {12'h0, 40'hff_ffff_ffff << r[63:61], r[4] | r[5], 11'h0} :
                        {42'h0, r[21:12] & (10'h3ff << r[63:61]), 9'h0, r[2:0]});
                    rd(`IDX_VAR_FIRST + {8'h0, r[63:60]});
                end
                2'd1: wr(`IDX_DEFAULT_TYPE, {52'h0, r[11] | r[12], r[10], 7'h0, r[2:0]});
                2'd2: wr(`IDX_FIXED_E8000 + {10'h0, r[9:8]}, rnd() & 64'h0505_0505_0505_0505);
                default: look({30'h0, r[21:0]});
            endcase
        end
        tally_and_finish;
    end
endmodule // memory_type_range_lookup_test
